//--- bpe_pkg.sv
package bpe_pkg;

  // ----------------------------------------------------------------
  // Bus indices and register map
  // ----------------------------------------------------------------
  localparam int BPE_PRI = 0;
  localparam int BPE_SEC = 1;
  localparam int BPE_NBUS = 2;

  localparam logic [31:0] BPE_OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] BPE_OFF_STATUS = 32'h0000_0004;
  localparam logic [31:0] BPE_OFF_MASK = 32'h0000_0008;

  // Control register fields.
  localparam int BPE_CTRL_PRI_RESP = 0;
  localparam int BPE_CTRL_SEC_RESP = 1;
  localparam int BPE_CTRL_SERR_EN = 2;
  localparam int BPE_CTRL_PW_SERR_DIS = 3;
  localparam int BPE_CTRL_W = 4;
  localparam logic [3:0] BPE_CTRL_RST = 4'h0;

  // Status and mask register fields.
  localparam int BPE_ST_PRI_DET = 0;
  localparam int BPE_ST_PRI_DPAR = 1;
  localparam int BPE_ST_SEC_DET = 2;
  localparam int BPE_ST_SEC_DPAR = 3;
  localparam int BPE_ST_SIG_SERR = 4;
  localparam int BPE_ST_W = 5;
  localparam logic [4:0] BPE_ST_RST = 5'h00;
  localparam logic [4:0] BPE_MASK_RST = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Parity error pin fires this many clocks after the data phase.
  localparam int BPE_PERR_DELAY_CLK = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Role of the bridge in a data phase on one bus.
  typedef enum logic [2:0] {
    BPE_K_IDLE,
    BPE_K_TGT_PW,
    BPE_K_TGT_DW,
    BPE_K_TGT_RD,
    BPE_K_MST_RD,
    BPE_K_MST_PW,
    BPE_K_MST_DW
  } bpe_kind_e;

  // One completed data phase as seen by the bus interface.
  typedef struct packed {
    logic valid;
    bpe_kind_e kind;
    logic parityBad;
    logic perrSeen;
    logic initErr;
  } bpe_evt_s;

endpackage : bpe_pkg

//--- bpe_parity_report.sv
`timescale 1ns/10ps
module bpe_parity_report
  import bpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bpe_evt_s [BPE_NBUS-1:0] busEvt,
  output logic [BPE_NBUS-1:0] fwdBadParity,
  output logic primaryParityErrorN,
  output logic primaryParityErrorOe,
  output logic secondaryParityErrorN,
  output logic secondaryParityErrorOe,
  output logic primarySystemErrorN,
  output logic primarySystemErrorOe,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic [BPE_CTRL_W-1:0] ctrl;
  logic [BPE_ST_W-1:0] status;
  logic [BPE_ST_W-1:0] mask;
  logic [BPE_ST_W-1:0] stSet;

  // The access is answered in its third cycle; writes land on that edge.
  wire accDone = psel & penable & pready;
  wire hitCtrl = (paddr == BPE_OFF_CTRL);
  wire hitStatus = (paddr == BPE_OFF_STATUS);
  wire hitMask = (paddr == BPE_OFF_MASK);
  wire hitAny = hitCtrl | hitStatus | hitMask;
  wire wrCtrl = accDone & pwrite & hitCtrl;
  wire wrStatus = accDone & pwrite & hitStatus;
  wire wrMask = accDone & pwrite & hitMask;
  wire [BPE_ST_W-1:0] stClr = wrStatus ? pwdata[BPE_ST_W-1:0] : '0;
  wire [31:0] rdMux = hitCtrl ? {{(32-BPE_CTRL_W){1'b0}}, ctrl} :
                      hitStatus ? {{(32-BPE_ST_W){1'b0}}, status} :
                      hitMask ? {{(32-BPE_ST_W){1'b0}}, mask} : 32'h0000_0000;

  wire priResp = ctrl[BPE_CTRL_PRI_RESP];
  wire secResp = ctrl[BPE_CTRL_SEC_RESP];
  wire bothResp = priResp & secResp;
  wire [BPE_NBUS-1:0] respEn = {secResp, priResp};

  // ----------------------------------------------------------------
  // Per-bus parity handling
  // ----------------------------------------------------------------
  logic [BPE_NBUS-1:0] detSet;
  logic [BPE_NBUS-1:0] dparSet;
  logic [BPE_NBUS-1:0] serrHit;
  logic [BPE_NBUS-1:0] dwPend;
  logic [BPE_NBUS-1:0] perrFire;
  logic [BPE_NBUS-1:0] perrStage;
  logic [BPE_NBUS-1:0] perrOeReg;
  logic [BPE_NBUS-1:0] perrPinN;

  genvar gb;
  generate
    for (gb = 0; gb < BPE_NBUS; gb++) begin : g_bus
      localparam int OTH = BPE_NBUS - 1 - gb;
      wire v = busEvt[gb].valid;
      wire bad = busEvt[gb].parityBad;
      wire perrIn = busEvt[gb].perrSeen;
      wire isTgtWr = (busEvt[gb].kind == BPE_K_TGT_PW) |
                     (busEvt[gb].kind == BPE_K_TGT_DW);
      wire isMstRd = (busEvt[gb].kind == BPE_K_MST_RD);
      wire isMstWr = (busEvt[gb].kind == BPE_K_MST_PW) |
                     (busEvt[gb].kind == BPE_K_MST_DW);
      // Only errors seen on this bus, as write target or read master.
      wire det = v & bad & (isTgtWr | isMstRd);
      // Delayed write completion carrying an error from the far bus.
      wire echo = v & (busEvt[gb].kind == BPE_K_TGT_DW) & dwPend[gb] & ~bad;
      // Posted-write serr disable only gates the downstream case.
      wire pwOk = (gb == BPE_SEC) ? ~ctrl[BPE_CTRL_PW_SERR_DIS] : 1'b1;

      // Detected parity bit ignores the response enables.
      assign detSet[gb] = det;
      // Data parity bit only while mastering this bus with response on.
      assign dparSet[gb] = v & respEn[gb] &
                           ((isMstRd & bad) | (isMstWr & perrIn));
      // Posted write error reported by target, not forwarded from initiator.
      assign serrHit[gb] = v & (busEvt[gb].kind == BPE_K_MST_PW) & perrIn &
                           ~busEvt[gb].initErr & pwOk & bothResp &
                           ctrl[BPE_CTRL_SERR_EN];
      // Pin fires on local detection, or on the delayed write echo.
      assign perrFire[gb] = (det & respEn[gb]) | (echo & bothResp);

      // Remember a target error on our delayed write for the initiator bus.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          dwPend[OTH] <= 1'b0;
        end else if (v & (busEvt[gb].kind == BPE_K_MST_DW) & perrIn &
                     ~busEvt[gb].initErr) begin
          dwPend[OTH] <= 1'b1;
        end else if (busEvt[OTH].valid &
                     (busEvt[OTH].kind == BPE_K_TGT_DW)) begin
          dwPend[OTH] <= 1'b0;
        end
      end

      // Two-clock delay to the parity error pin, driven for one clock.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          perrStage[gb] <= 1'b0;
          perrOeReg[gb] <= 1'b0;
          perrPinN[gb] <= 1'b1;
        end else begin
          perrStage[gb] <= perrFire[gb];
          perrOeReg[gb] <= perrStage[gb];
          perrPinN[gb] <= ~perrStage[gb];
        end
      end

      // Bad parity from a posted write target phase travels with the data.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          fwdBadParity[gb] <= 1'b0;
        end else begin
          fwdBadParity[gb] <= v & bad &
                              (busEvt[gb].kind == BPE_K_TGT_PW);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status, system error and interrupt
  // ----------------------------------------------------------------
  wire serrAny = |serrHit;

  assign stSet = {serrAny, dparSet[BPE_SEC], detSet[BPE_SEC],
                  dparSet[BPE_PRI], detSet[BPE_PRI]};

  // Control and mask registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= BPE_CTRL_RST;
      mask <= BPE_MASK_RST;
    end else begin
      if (wrCtrl) ctrl <= pwdata[BPE_CTRL_W-1:0];
      if (wrMask) mask <= pwdata[BPE_ST_W-1:0];
    end
  end

  // Sticky status; a new event wins over a same-cycle write-one clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status <= BPE_ST_RST;
    end else begin
      status <= (status & ~stClr) | stSet;
    end
  end

  // System error pin is open drain, pulsed low for one clock.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      primarySystemErrorN <= 1'b1;
      primarySystemErrorOe <= 1'b0;
    end else begin
      primarySystemErrorN <= ~serrAny;
      primarySystemErrorOe <= serrAny;
    end
  end

  // Interrupt is high while any unmasked status bit is set.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // APB answer: one wait state, error on unmapped addresses.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hitAny;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pin mapping
  // ----------------------------------------------------------------
  assign primaryParityErrorN = perrPinN[BPE_PRI];
  assign primaryParityErrorOe = perrOeReg[BPE_PRI];
  assign secondaryParityErrorN = perrPinN[BPE_SEC];
  assign secondaryParityErrorOe = perrOeReg[BPE_SEC];

endmodule : bpe_parity_report

//--- bpe_parity_report_props.sv
`timescale 1ns/10ps
// ----------------------------------------
// Parity reporting checker
// ----------------------------------------
module bpe_parity_report_props
  import bpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire bpe_evt_s [BPE_NBUS-1:0] busEvt,
  input wire logic [BPE_NBUS-1:0] fwdBadParity,
  input wire logic primaryParityErrorN,
  input wire logic primaryParityErrorOe,
  input wire logic secondaryParityErrorN,
  input wire logic secondaryParityErrorOe,
  input wire logic primarySystemErrorN,
  input wire logic primarySystemErrorOe
);
  logic [3:0] ctrl;
  logic [1:0] badPw;
  logic [1:0] perrMw;
  logic serrOk;
  function automatic logic isK(bpe_evt_s e, bpe_kind_e k);
    return e.valid && e.kind == k;
  endfunction : isK
  // Flags the error phases of interest on each bus.
  assign badPw[0] = isK(busEvt[0], BPE_K_TGT_PW) && busEvt[0].parityBad;
  assign badPw[1] = isK(busEvt[1], BPE_K_TGT_PW) && busEvt[1].parityBad;
  assign perrMw[0] = isK(busEvt[0], BPE_K_MST_PW) && busEvt[0].perrSeen
    && !busEvt[0].initErr;
  assign perrMw[1] = isK(busEvt[1], BPE_K_MST_PW) && busEvt[1].perrSeen
    && !busEvt[1].initErr;
  assign serrOk = ctrl[BPE_CTRL_SERR_EN] && ctrl[1:0] == 2'h3;
  // Shadows the control register from completed writes.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= BPE_CTRL_RST;
    end else if (psel && penable && pready && pwrite && paddr == 0) begin
      ctrl <= pwdata[3:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  pri_perr_a: assert property (
    badPw[0] && ctrl[0] |-> ##2 !primaryParityErrorN && primaryParityErrorOe)
    else $error("primary parity pin missing");
  pri_quiet_a: assert property (
    badPw[0] && !ctrl[0] |-> ##2 primaryParityErrorN)
    else $error("primary parity pin without enable");
  sec_perr_a: assert property (
    badPw[1] && ctrl[1] |-> ##2 !secondaryParityErrorN && secondaryParityErrorOe)
    else $error("secondary parity pin missing");
  fwd_bad_a: assert property (
    badPw != 2'h0 |=> fwdBadParity == $past(badPw))
    else $error("bad parity not forwarded");
  serr_dn_a: assert property (
    perrMw[1] && serrOk && !ctrl[3] |=> !primarySystemErrorN)
    else $error("downstream system error missing");
  serr_dis_a: assert property (
    perrMw == 2'h2 && ctrl[3] |=> primarySystemErrorN)
    else $error("system error despite disable");
  serr_up_a: assert property (
    perrMw[0] && serrOk |=> !primarySystemErrorN && primarySystemErrorOe)
    else $error("upstream system error missing");
  serr_fwd_a: assert property (
    isK(busEvt[0], BPE_K_MST_PW) && busEvt[0].initErr && !perrMw[1]
    |=> primarySystemErrorN)
    else $error("system error for forwarded parity");
endmodule : bpe_parity_report_props

bind bpe_parity_report bpe_parity_report_props chk_i (
  .core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .busEvt, .fwdBadParity, .primaryParityErrorN, .primaryParityErrorOe,
  .secondaryParityErrorN, .secondaryParityErrorOe, .primarySystemErrorN,
  .primarySystemErrorOe
);

//--- bpe_bus_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Far side data phase source
// ----------------------------------------
module bpe_bus_model
  import bpe_pkg::*;
(
  input wire logic core_clk,
  output bpe_evt_s [BPE_NBUS-1:0] busEvt
);
  // Both buses stay idle until a phase is requested.
  initial busEvt = '0;
  // Reports one data phase for one clock; flags are bad, perr, init.
  task automatic send(input int b, input bpe_kind_e k, input logic [2:0] f);
    @(posedge core_clk);
    busEvt[b] <= '{1'h1, k, f[2], f[1], f[0]};
    @(posedge core_clk);
    busEvt[b] <= '0;
  endtask : send
endmodule : bpe_bus_model

//--- testbench.sv
`timescale 1ns/10ps
// ----------------------------------------
// Parity reporting testbench
// ----------------------------------------
module testbench
  import bpe_pkg::*;
;
  logic core_clk, srst, psel, penable, pwrite, pready, slvErr, se, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pN, pOe, sN, sOe, yN, yOe;
  logic [1:0] fwd;
  bpe_evt_s [BPE_NBUS-1:0] busEvt;
  int err_count = 0, total_checks = 0, pCnt = 0, sCnt = 0, yCnt = 0, base;
  int fCnt = 0;
  bpe_parity_report uut (.core_clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr(slvErr), .busEvt,
    .fwdBadParity(fwd), .primaryParityErrorN(pN), .primaryParityErrorOe(pOe),
    .secondaryParityErrorN(sN), .secondaryParityErrorOe(sOe),
    .primarySystemErrorN(yN), .primarySystemErrorOe(yOe), .irq);
  bpe_bus_model bus (.core_clk, .busEvt);
  // Clock and pin pulse counters.
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    pCnt <= pCnt + int'(!pN);
    sCnt <= sCnt + int'(!sN);
    yCnt <= yCnt + int'(!yN);
    fCnt <= fCnt + int'(fwd[0]) + 2 * int'(fwd[1]);
  end
  // Forwarded bad parity counts 1000 per primary and 2000 per secondary.
  function automatic int pins();
    return fCnt * 1000 + pCnt * 100 + sCnt * 10 + yCnt;
  endfunction : pins
  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    se = slvErr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  task automatic ev(input int b, input bpe_kind_e k, input logic [2:0] f);
    base = pins();
    bus.send(b, k, f);
    repeat (4) @(posedge core_clk);
  endtask : ev
  // Reads and compares status, compares pin pulses, then clears status.
  task automatic st(input logic [31:0] e, input int p);
    apb(1'h0, BPE_OFF_STATUS, 0);
    chk(rd, e, "status");
    chk(pins() - base, p, "pin pulses");
    apb(1'h1, BPE_OFF_STATUS, 32'h0000_001F);
  endtask : st
  task automatic t_post();
    base = pins();
    st(0, 0);
    apb(1'h0, 32'h0000_0010, 0);
    chk({rd[31:1], se}, 1, "unmapped");
    apb(1'h1, BPE_OFF_CTRL, 32'h0000_0003);
    ev(0, BPE_K_TGT_PW, 3'h4);
    st(32'h0000_0001, 1100);
    ev(1, BPE_K_TGT_PW, 3'h4);
    st(32'h0000_0004, 2010);
    apb(1'h1, BPE_OFF_CTRL, 0);
    ev(0, BPE_K_TGT_PW, 3'h4);
    st(32'h0000_0001, 1000);
    ev(1, BPE_K_TGT_PW, 3'h4);
    st(32'h0000_0004, 2000);
    $display("posted write target test done");
  endtask : t_post
  // Read master error and delayed write error echoed to the initiator.
  task automatic t_dw();
    apb(1'h1, BPE_OFF_CTRL, 32'h0000_0003);
    ev(0, BPE_K_MST_RD, 3'h4);
    st(32'h0000_0003, 100);
    ev(1, BPE_K_MST_DW, 3'h2);
    ev(0, BPE_K_TGT_DW, 3'h0);
    st(32'h0000_0008, 100);
    $display("delayed write test done");
  endtask : t_dw
  task automatic t_serr();
    apb(1'h1, BPE_OFF_CTRL, 32'h0000_0007);
    ev(1, BPE_K_MST_PW, 3'h2);
    st(32'h0000_0018, 1);
    ev(0, BPE_K_MST_PW, 3'h3);
    st(32'h0000_0002, 0);
    ev(0, BPE_K_MST_PW, 3'h2);
    st(32'h0000_0012, 1);
    apb(1'h1, BPE_OFF_CTRL, 32'h0000_000F);
    ev(1, BPE_K_MST_PW, 3'h2);
    st(32'h0000_0008, 0);
    apb(1'h1, BPE_OFF_CTRL, 32'h0000_0004);
    ev(1, BPE_K_MST_PW, 3'h2);
    st(0, 0);
    $display("target error test done");
  endtask : t_serr
  task automatic t_irq();
    ev(0, BPE_K_TGT_PW, 3'h4);
    chk({31'h0, irq}, 0, "masked irq");
    apb(1'h1, BPE_OFF_MASK, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 1, "irq");
    apb(1'h1, BPE_OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 0, "cleared irq");
    $display("interrupt test done");
  endtask : t_irq
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Main sequence and watchdog.
  initial begin
    srst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    t_post();
    t_dw();
    t_serr();
    t_irq();
    results();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    results();
  end
endmodule : testbench
